//--- ifd_decoder.sv
// decoder for load-constant and pc-relative word load
// assumes fetch offers one word with valid/ready; data port answers with ack
module ifd_decoder (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        insn_valid,
   input  wire logic [15:0] insn_word,
   input  wire logic [31:0] insn_addr,
   output logic             insn_ready,
   output logic             dmem_req,
   output logic [31:0]      dmem_addr,
   input  wire logic        dmem_ack,
   input  wire logic [15:0] dmem_rdata,
   input  wire logic        fetch_busy,
   output logic             flag_q,
   output logic             wb_valid_q,
   output logic [3:0]       wb_reg_q,
   output logic [31:0]      wb_data_q,
   output logic             illegal_q,
   input  wire logic [3:0]  dbg_raddr,
   output logic [31:0]      dbg_rdata
);
   ifd_regs_if rf ();
   ifd_pkg::ifd_state_t state_q;
   logic [3:0]  load_dst_q;
   logic        load_pend_q;
   logic [31:0] addr_q;

   ifd_regfile u_rf (
      .clk     (clk),
      .sys_rst (sys_rst),
      .rf      (rf)
   );

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   function automatic logic [3:0] dest_reg_field(input logic [15:0] w);
      return w[11:8];
   endfunction

   function automatic logic reads_reg(input logic [15:0] w, input logic [3:0] r);
      // neither supported op reads a general register as a source
      return 1'b0;
   endfunction

   logic [3:0]  op;
   logic        is_const;
   logic        is_word;
   logic        hazard;
   logic [31:0] pc_addr;
   assign op       = insn_word[15:12];
   assign is_const = op == ifd_pkg::OP_LOAD_CONST;
   assign is_word  = op == ifd_pkg::OP_PC_WORD;
   // reader of a register loaded by the prior memory load waits a cycle
   assign hazard   = load_pend_q && reads_reg(insn_word, load_dst_q);
   assign pc_addr  = insn_addr + ifd_pkg::PC_AHEAD
                   + ({24'h00_0000, insn_word[7:0]} << ifd_pkg::WORD_SHIFT);

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign insn_ready = (state_q == ifd_pkg::ST_IDLE) && !hazard;
   assign dmem_req   = (state_q == ifd_pkg::ST_MEM_REQ);
   assign dmem_addr  = addr_q;
   assign rf.raddr   = dbg_raddr;
   assign dbg_rdata  = rf.rdata;

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ifd_pkg::ST_IDLE;
         addr_q  <= ifd_pkg::PC_RESET;
      end else begin
         case (state_q)
            ifd_pkg::ST_IDLE: begin
               if (insn_valid && insn_ready && is_word) begin
                  addr_q  <= pc_addr;
                  state_q <= ifd_pkg::ST_MEM_REQ;
               end
            end
            ifd_pkg::ST_MEM_REQ: begin
               // fetch owns the memory path while fetch_busy is high; data access waits
               if (!fetch_busy) begin
                  state_q <= ifd_pkg::ST_MEM_WAIT;
               end
            end
            ifd_pkg::ST_MEM_WAIT: begin
               if (dmem_ack) begin
                  state_q <= ifd_pkg::ST_IDLE;
               end
            end
            default: state_q <= ifd_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // write back
   // ----------------------------------------
   logic        we_d;
   logic [3:0]  wa_d;
   logic [31:0] wd_d;
   // constant op writes in its accept cycle; the echo follows one cycle later
   always_comb begin
      we_d = 1'b0;
      wa_d = dest_reg_field(insn_word);
      wd_d = {{24{insn_word[7]}}, insn_word[7:0]};
      if (state_q == ifd_pkg::ST_IDLE && insn_valid && insn_ready && is_const) begin
         we_d = 1'b1;
      end else if (state_q == ifd_pkg::ST_MEM_WAIT && dmem_ack) begin
         we_d = 1'b1;
         wa_d = load_dst_q;
         wd_d = {{16{dmem_rdata[15]}}, dmem_rdata};
      end
   end
   assign rf.we    = we_d;
   assign rf.waddr = wa_d;
   assign rf.wdata = wd_d;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_valid_q <= 1'b0;
         wb_reg_q   <= 4'h0;
         wb_data_q  <= ifd_pkg::REG_RESET;
      end else begin
         wb_valid_q <= we_d;
         wb_reg_q   <= wa_d;
         wb_data_q  <= wd_d;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_dst_q  <= 4'h0;
         load_pend_q <= 1'b0;
      end else begin
         if (state_q == ifd_pkg::ST_IDLE && insn_valid && insn_ready && is_word) begin
            load_dst_q <= dest_reg_field(insn_word);
         end
         load_pend_q <= (state_q == ifd_pkg::ST_MEM_WAIT && dmem_ack);
      end
   end

   // neither op touches the flag; it only holds its value
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_q <= ifd_pkg::FLAG_RESET;
      end else begin
         flag_q <= flag_q;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= insn_valid && insn_ready && !is_const && !is_word;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_const_write: assert property (insn_valid && insn_ready && is_const |=>
      wb_valid_q && wb_reg_q == $past(insn_word[11:8]) && wb_data_q == {{24{$past(insn_word[7])}}, $past(insn_word[7:0])})
      else $error("constant load write wrong");
   a_reg_select: assert property (wb_valid_q && $past(state_q) == ifd_pkg::ST_IDLE |->
      wb_reg_q == $past(insn_word[11:8]))
      else $error("register field mismatch");
   a_word_addr: assert property (insn_valid && insn_ready && is_word |=>
      dmem_addr == $past(insn_addr) + 32'h4 + {23'h0, $past(insn_word[7:0]), 1'b0})
      else $error("pc relative address wrong");
   a_disp_scale: assert property (insn_valid && insn_ready && is_word |=>
      dmem_addr[0] == $past(insn_addr[0]))
      else $error("displacement not scaled");
   a_contend_stall: assert property (dmem_req && fetch_busy |=> dmem_req)
      else $error("data access during fetch");
   a_word_signext: assert property (state_q == ifd_pkg::ST_MEM_WAIT && dmem_ack |=>
      wb_valid_q && wb_data_q == {{16{$past(dmem_rdata[15])}}, $past(dmem_rdata)})
      else $error("word load extension wrong");
   a_flag_kept: assert property (##1 $stable(flag_q))
      else $error("flag changed");
   a_load_busy: assert property (state_q != ifd_pkg::ST_IDLE |-> !insn_ready)
      else $error("accepted during load");
   a_req_hold: assert property (dmem_req && fetch_busy |=> $stable(dmem_addr))
      else $error("data address moved while waiting");
   a_load_dest: assert property (insn_valid && insn_ready && is_word |=>
      load_dst_q == $past(insn_word[11:8]))
      else $error("load destination not captured");
   a_word_dest: assert property (state_q == ifd_pkg::ST_MEM_WAIT && dmem_ack |=>
      wb_reg_q == $past(load_dst_q))
      else $error("word load wrote wrong register");
   a_word_no_write: assert property (insn_valid && insn_ready && is_word |=> !wb_valid_q)
      else $error("word load wrote before data");
   a_wait_ack: assert property (state_q == ifd_pkg::ST_MEM_WAIT && !dmem_ack |=> !wb_valid_q)
      else $error("write without data answer");
   a_ack_return: assert property (state_q == ifd_pkg::ST_MEM_WAIT && dmem_ack |=> insn_ready)
      else $error("non-reader held after load");

   // ----------------------------------------
   // coverage
   // ----------------------------------------
   c_const: cover property (insn_valid && insn_ready && is_const);
   c_word: cover property (state_q == ifd_pkg::ST_MEM_WAIT && dmem_ack);
   c_contend: cover property (dmem_req && fetch_busy);
   c_after_load: cover property (load_pend_q && insn_valid && insn_ready);
   c_illegal: cover property (insn_valid && insn_ready && !is_const && !is_word);
endmodule : ifd_decoder

//--- ifd_far_side.sv
// far-side model: fetch contention and 16-bit data memory
// assumes the request is held until an edge with fetch_busy low
module ifd_far_side (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        dmem_req,
   input  wire logic [31:0] dmem_addr,
   input  wire logic [31:0] busy_cycles,
   input  wire logic [31:0] ack_delay,
   output logic             dmem_ack,
   output logic [15:0]      dmem_rdata,
   output logic             fetch_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int          st;
   int          n;
   logic [31:0] a;
   // ----------------------------------------
   // memory path, driven at the falling edge
   // ----------------------------------------
   always @(negedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st = 0;
         n = 0;
         fetch_busy = 1'b0;
         dmem_ack = 1'b0;
         dmem_rdata = 16'h0000;
      end else begin
         dmem_ack = 1'b0;
         // released data line: inverts every bit each cycle, so the last word shows again every second cycle
         dmem_rdata = ~dmem_rdata;
         if (st == 0) begin
            if (dmem_req) begin
               a = dmem_addr;
               n = busy_cycles;
               fetch_busy = (n > 0);
               st = 1;
            end
         end else if (st == 1) begin
            if (fetch_busy) begin
               n = n - 1;
               fetch_busy = (n > 0);
            end else begin
               n = ack_delay;
               st = 2;
            end
         end
         if (st == 2) begin
            if (n == 0) begin
               dmem_ack = 1'b1;
               dmem_rdata = {a[1], a[14:0] ^ 15'h5a3c};
               st = 0;
            end else begin
               n = n - 1;
            end
         end
      end
   end
endmodule : ifd_far_side

//--- ifd_pkg.sv
// package for the instruction field decoder: opcodes, widths, flags
// assumes a 16-bit instruction word and a 32-bit data path
package ifd_pkg;
   localparam int           WORD_W        = 32;
   localparam int           INSN_W        = 16;
   localparam int           REG_CNT       = 16;
   localparam logic [3:0]   OP_LOAD_CONST = 4'he;
   localparam logic [3:0]   OP_PC_WORD    = 4'h9;
   localparam logic [31:0]  PC_AHEAD      = 32'h0000_0004;
   localparam int           WORD_SHIFT    = 1;
   localparam logic [31:0]  PC_RESET      = 32'h0000_0000;
   localparam logic [31:0]  REG_RESET     = 32'h0000_0000;
   localparam logic         FLAG_RESET    = 1'b0;
   typedef enum logic [1:0] {ST_IDLE, ST_MEM_REQ, ST_MEM_WAIT} ifd_state_t;
endpackage : ifd_pkg

//--- ifd_regfile.sv
// sixteen-entry general register file, registered read data
// assumes single clock, writes take effect at the next edge
module ifd_regfile (
   input  wire logic clk,
   input  wire logic sys_rst,
   ifd_regs_if.mem   rf
);
   logic [31:0] regs_q [ifd_pkg::REG_CNT];

   // ----------------------------------------
   // storage
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < ifd_pkg::REG_CNT; g++) begin : g_reg
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               regs_q[g] <= ifd_pkg::REG_RESET;
            end else if (rf.we && rf.waddr == 4'(g)) begin
               regs_q[g] <= rf.wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rf.rdata <= ifd_pkg::REG_RESET;
      end else begin
         rf.rdata <= regs_q[rf.raddr];
      end
   end
endmodule : ifd_regfile

//--- ifd_regs_if.sv
// interface between the decoder and its register file
// assumes one write port and one registered read port
interface ifd_regs_if;
   logic        we;
   logic [3:0]  waddr;
   logic [31:0] wdata;
   logic [3:0]  raddr;
   logic [31:0] rdata;
   modport core (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ifd_regs_if

//--- testbench.sv
// self-checking bench for the constant and pc-relative word loads
// assumes the decoder and the far-side model compiled before it
`define CHK(nm, s, e) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
   $display("unexpected %s expected %h seen %h", nm, e, s); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, sys_rst = 1'b1, insn_valid = 1'b0, insn_ready, dmem_req, dmem_ack, fetch_busy;
   logic flag_q, wb_valid_q, illegal_q;
   logic [15:0] insn_word = 16'h0000, dmem_rdata;
   logic [31:0] insn_addr = 32'h0000_2000, dmem_addr, wb_data_q, dbg_rdata;
   logic [3:0]  wb_reg_q, dbg_raddr = 4'h0;
   int          busy_cycles = 0, ack_delay = 0, miscompares = 0, checks_done = 0;
   always #10 clk = ~clk;
   ifd_decoder dut (.clk(clk), .sys_rst(sys_rst), .insn_valid(insn_valid), .insn_word(insn_word),
      .insn_addr(insn_addr), .insn_ready(insn_ready), .dmem_req(dmem_req), .dmem_addr(dmem_addr),
      .dmem_ack(dmem_ack), .dmem_rdata(dmem_rdata), .fetch_busy(fetch_busy), .flag_q(flag_q),
      .wb_valid_q(wb_valid_q), .wb_reg_q(wb_reg_q), .wb_data_q(wb_data_q), .illegal_q(illegal_q),
      .dbg_raddr(dbg_raddr), .dbg_rdata(dbg_rdata));
   ifd_far_side far_side (.clk(clk), .sys_rst(sys_rst), .dmem_req(dmem_req), .dmem_addr(dmem_addr),
      .busy_cycles(busy_cycles), .ack_delay(ack_delay), .dmem_ack(dmem_ack), .dmem_rdata(dmem_rdata),
      .fetch_busy(fetch_busy));
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic conclude;
      if (miscompares == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   // sixteen constants back to back, then read every register back
   task automatic t_const;
      logic [7:0] im;
      for (int r = 0; r <= 16; r++) begin
         @(negedge clk);
         if (r > 0) begin
            `CHK("wb_valid", wb_valid_q, 1'b1)
            `CHK("wb_reg", wb_reg_q, 4'(r - 1))
            `CHK("wb_data", wb_data_q, {{24{im[7]}}, im})
         end
         im = 8'(r * 17);
         insn_valid = (r < 16);
         insn_word = {ifd_pkg::OP_LOAD_CONST, 4'(r), im};
      end
      for (int r = 0; r <= 16; r++) begin
         if (r > 0) `CHK("dbg_rdata", dbg_rdata, {{24{im[7]}}, im})
         im = 8'(r * 17);
         dbg_raddr = 4'(r);
         @(negedge clk);
      end
      `CHK("flag", flag_q, 1'b0)
   endtask : t_const
   // one word load with b cycles of fetch contention and an answer delay of w cycles
   task automatic t_word(input logic [7:0] d, input int b, input int w, input logic [3:0] dst);
      logic [31:0] a;
      logic [15:0] m;
      int          k;
      @(negedge clk);
      busy_cycles = b;
      ack_delay = w;
      insn_valid = 1'b1;
      insn_word = {ifd_pkg::OP_PC_WORD, dst, d};
      @(negedge clk);
      insn_valid = 1'b0;
      a = insn_addr + 32'h0000_0004 + {23'h000000, d, 1'b0};
      `CHK("dmem_req", dmem_req, 1'b1)
      `CHK("dmem_addr", dmem_addr, a)
      `CHK("ready", insn_ready, 1'b0)
      k = 0;
      while (wb_valid_q !== 1'b1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      if (k == 40) begin
         miscompares++;
         conclude();
      end
      m = {a[1], a[14:0] ^ 15'h5a3c};
      `CHK("wb_reg", wb_reg_q, dst)
      `CHK("wb_data", wb_data_q, {{16{m[15]}}, m})
      `CHK("cycles", k, b + w + 2)
      `CHK("flag", flag_q, 1'b0)
      `CHK("ready after", insn_ready, 1'b1)
      // a constant load reads no register, so it must not wait behind the load
      insn_valid = 1'b1;
      insn_word = {ifd_pkg::OP_LOAD_CONST, dst ^ 4'h8, d};
      dbg_raddr = dst;
      @(negedge clk);
      insn_valid = 1'b0;
      `CHK("follow valid", wb_valid_q, 1'b1)
      `CHK("follow reg", wb_reg_q, dst ^ 4'h8)
      `CHK("loaded reg", dbg_rdata, {{16{m[15]}}, m})
   endtask : t_word
   // unsupported opcode is dropped without a register write
   task automatic t_illegal;
      @(negedge clk);
      insn_valid = 1'b1;
      insn_word = 16'h6123;
      @(negedge clk);
      insn_valid = 1'b0;
      `CHK("illegal", illegal_q, 1'b1)
      `CHK("wb_valid", wb_valid_q, 1'b0)
   endtask : t_illegal
   initial begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      t_const();
      t_word(8'h00, 0, 0, 4'h3);
      t_word(8'hff, 2, 3, 4'hf);
      t_word(8'h81, 1, 0, 4'h0);
      t_illegal();
      conclude();
   end
endmodule : testbench
